// ### acsc_ctrl.v
// serial command decode, conversion sequencing and power mode control
`timescale 1ns/10ps
`include "acsc_defs.vh"
module acsc_ctrl #(
   parameter CMD_BITS = `ACSC_CMD_BITS,
   parameter RES_BITS = `ACSC_RES_BITS
) (
   input wire clk_sys,
   input wire arst_n,
   input wire cs_n,
   input wire sclk,
   input wire din,
   input wire shutdown_n,
   input wire [11:0] sar_result,
   output reg dout,
   output wire dout_oe,
   output reg conversion_strobe,
   output wire strobe_oe,
   output wire [2:0] chan_sel,
   output wire polarity_select,
   output wire input_config_select,
   output wire [1:0] power_mode,
   output wire full_power,
   output wire sample_hold,
   output wire converting,
   output wire [3:0] pos_input,
   output wire [4:0] neg_input
);
   //////////////////////////////////////////////////////////////////////
   // synchronised pins
   wire cs_n_s; // chip select level
   wire sclk_s; // serial clock level
   wire din_s; // data level
   wire shutdown_n_n_s; // shutdown level
   acsc_sync u_cs (.clk_sys(clk_sys), .arst_n(arst_n), .d(cs_n), .q(cs_n_s));
   acsc_sync u_ck (.clk_sys(clk_sys), .arst_n(arst_n), .d(sclk), .q(sclk_s));
   acsc_sync u_di (.clk_sys(clk_sys), .arst_n(arst_n), .d(din), .q(din_s));
   acsc_sync u_sd (.clk_sys(clk_sys), .arst_n(arst_n), .d(shutdown_n), .q(shutdown_n_n_s));
   reg sclk_d1_q; // previous serial clock level
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) sclk_d1_q <= 1'b0;
      else sclk_d1_q <= sclk_s;
   end
   wire rise = sclk_s & ~sclk_d1_q; // serial rising edge
   wire fall = ~sclk_s & sclk_d1_q; // serial falling edge
   wire active = ~cs_n_s; // select held low
   //////////////////////////////////////////////////////////////////////
   // state machine
   localparam ST_IDLE = 2'h0; // hunting for start bit
   localparam ST_CMD = 2'h1; // shifting the rest of the byte
   localparam ST_ARM = 2'h2; // waiting for falling edge after bit eight
   localparam ST_CONV = 2'h3; // strobe and result shifting
   reg [1:0] st_q;
   reg [2:0] cmd_cnt_q; // command bits still to come, less one
   reg [6:0] sh_q; // command shift register, bits 6..0
   reg [6:0] cmd_q; // latched byte below the start bit
   reg [4:0] conv_cnt_q; // falling edges since conversion start
   reg [11:0] res_q; // result shifter
   reg [1:0] pm_q; // mode entered between conversions
   reg done_once_q; // a conversion has completed
   reg [11:0] latched_q; // held sar answer
   // overlapped start window: after result bit six is out
   wire conv_open = (st_q == ST_CONV) && (conv_cnt_q > {1'b0, `ACSC_B6_EDGE}); // R2
   // wrap bits 6..0 into the latched command fields
   assign chan_sel = cmd_q[`ACSC_BIT_SEL_HI:`ACSC_BIT_SEL_LO]; // R9
   assign polarity_select = cmd_q[`ACSC_BIT_POL]; // R10
   assign input_config_select = cmd_q[`ACSC_BIT_CFG]; // R11
   assign power_mode = pm_q; // R12
   // full power while busy, in normal mode, or once a start bit is seen
   assign converting = (st_q != ST_IDLE); // R13
   assign full_power = shutdown_n_n_s & (converting | (pm_q == `ACSC_PM_NORMAL)); // R14 R17
   assign sample_hold = (st_q == ST_CONV);
   assign dout_oe = active;
   assign strobe_oe = active;
   // channel map: one-hot positive, negative bit4 means common input
   // single-ended: codes 001,101,010,110 pick inputs 0..3 against common
   // pseudo-differential: pairs 0/1 and 2/3, the code picks the polarity
   // unused codes select nothing rather than a wrong input
   function [8:0] chan_map;
      input [2:0] sel;
      input sgl;
      begin
         chan_map = 9'h000;
         case (sel)
            3'h1: chan_map = sgl ? 9'h030 : 9'h022; // in0 + , in1 -
            3'h5: chan_map = sgl ? 9'h050 : 9'h041; // in1 + , in0 -
            3'h2: chan_map = sgl ? 9'h090 : 9'h088; // in2 + , in3 -
            3'h6: chan_map = sgl ? 9'h110 : 9'h104; // in3 + , in2 -
            default: chan_map = 9'h000;
         endcase
      end
   endfunction
   wire [8:0] map_w = chan_map(chan_sel, input_config_select); // R25
   assign pos_input = map_w[8:5];
   assign neg_input = map_w[4:0];
   //////////////////////////////////////////////////////////////////////
   // main sequencing
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= ST_IDLE;
         cmd_cnt_q <= 3'h0;
         sh_q <= 7'h00;
         cmd_q <= 7'h00;
         conv_cnt_q <= 5'h00;
         res_q <= 12'h000;
         pm_q <= `ACSC_PM_RESET; // R6
         done_once_q <= 1'b0;
         latched_q <= 12'h000;
         dout <= 1'b0; // R8
         conversion_strobe <= 1'b0; // R6
      end else if (!shutdown_n_n_s) begin
         // hardware shutdown halts everything at once
         st_q <= ST_IDLE; // R14 R3
         conversion_strobe <= 1'b0;
         cmd_cnt_q <= 3'h0;
      end else begin
         if (!active) conversion_strobe <= 1'b0; // low once select returns
         case (st_q)
            ST_IDLE: begin
               // serial input stays alive in every soft power mode
               if (active && rise && din_s) begin // R1 R15
                  st_q <= ST_CMD; // R17
                  cmd_cnt_q <= 3'h6;
               end
            end
            ST_CMD: begin
               // select release is ignored once started
               if (rise) begin // R3
                  sh_q <= {sh_q[5:0], din_s};
                  if (cmd_cnt_q == 3'h0) st_q <= ST_ARM;
                  else cmd_cnt_q <= cmd_cnt_q - 3'h1;
               end
            end
            ST_ARM: begin
               if (fall) begin // R22
                  cmd_q <= sh_q;
                  latched_q <= sar_result;
                  conv_cnt_q <= 5'h00;
                  conversion_strobe <= 1'b1; // R23
                  st_q <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (rise && conv_cnt_q == 5'h00) begin
                  conversion_strobe <= 1'b0; // R23
                  // msb leaves now, so the shifter keeps only the rest
                  res_q <= {latched_q[10:0], 1'b0}; // R24
               end
               if (fall) conv_cnt_q <= conv_cnt_q + 5'h01;
               if (rise && conv_open && din_s && active) begin
                  // overlapped start bit; old result keeps going out
                  st_q <= ST_CMD; // R2 R4
                  cmd_cnt_q <= 3'h6;
                  done_once_q <= 1'b1;
                  pm_q <= cmd_q[`ACSC_BIT_PM_HI:`ACSC_BIT_PM_LO]; // R16
               end else if (fall && conv_cnt_q == 5'd`ACSC_CONV_CLKS - 5'd3) begin
                  st_q <= ST_IDLE;
                  done_once_q <= 1'b1;
                  pm_q <= cmd_q[`ACSC_BIT_PM_HI:`ACSC_BIT_PM_LO]; // R13 R16
               end
            end
            default: st_q <= ST_IDLE;
         endcase
         // result shifts out msb first on rising edges
         if (rise && (st_q == ST_CONV || st_q == ST_CMD || st_q == ST_ARM)) begin
            if (st_q == ST_CONV && conv_cnt_q == 5'h00) dout <= latched_q[11]; // R23
            else begin
               dout <= res_q[11];
               res_q <= {res_q[10:0], 1'b0};
            end
         end else if (rise && !done_once_q && st_q == ST_IDLE) begin
            dout <= 1'b0; // R8
         end
      end
   end
endmodule // acsc_ctrl

// ### acsc_ctrl_monitor.sv
// port checks for the serial command and power control block
`timescale 1ns/10ps
module acsc_ctrl_monitor (
   input wire clk_sys,
   input wire arst_n,
   input wire shutdown_n,
   input wire conversion_strobe,
   input wire [2:0] chan_sel,
   input wire input_config_select,
   input wire [1:0] power_mode,
   input wire full_power,
   input wire converting,
   input wire [3:0] pos_input,
   input wire [4:0] neg_input
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // pin held long enough to cross the synchroniser
   sequence s_shutdown_n_low;
      !shutdown_n [*5];
   endsequence
   sequence s_shutdown_n_high;
      shutdown_n [*5];
   endsequence
   a_strobe_in_conv: assert property (conversion_strobe |-> converting)
      else $error("strobe outside a conversion");
   a_strobe_one_period: assert property ($rose(conversion_strobe) |->
      conversion_strobe [*8] ##[1:24] !conversion_strobe) else $error("strobe width");
   a_shutdown_n_aborts: assert property (s_shutdown_n_low |-> !converting && !full_power)
      else $error("shutdown did not halt");
   a_full_in_conv: assert property (s_shutdown_n_high ##0 converting |-> full_power)
      else $error("not full power while converting");
   a_idle_power_mode: assert property (s_shutdown_n_high ##0 !converting |->
      full_power == (power_mode == 2'h3)) else $error("idle power mismatch");
   a_mode_at_end: assert property ($changed(power_mode) |->
      $past(converting)) else $error("mode changed outside conversion end");
   a_fields_in_conv: assert property ($changed({chan_sel, input_config_select}) |->
      converting) else $error("fields changed while idle");
   a_single_com_neg: assert property (input_config_select && chan_sel == 3'h5 |->
      pos_input == 4'h2 && neg_input == 5'h10) else $error("single-ended map");
   a_diff_pair_map: assert property (!input_config_select && chan_sel == 3'h1 |->
      pos_input == 4'h1 && neg_input == 5'h02) else $error("differential map");
endmodule // acsc_ctrl_monitor
bind acsc_ctrl acsc_ctrl_monitor u_mon (.clk_sys(clk_sys), .arst_n(arst_n),
   .shutdown_n(shutdown_n), .conversion_strobe(conversion_strobe), .chan_sel(chan_sel),
   .input_config_select(input_config_select), .power_mode(power_mode),
   .full_power(full_power), .converting(converting), .pos_input(pos_input),
   .neg_input(neg_input));

// ### acsc_ctrl_test.sv
// self-checking bench for the serial command and power control block
`timescale 1ns/10ps
module acsc_ctrl_test;
   reg clk_sys = 1'b0;
   reg arst_n = 1'b0;
   reg shutdown_n = 1'b1;
   reg [11:0] sar_result = 12'h000;
   reg [7:0] lfsr_q = 8'h57; // seed 87
   reg [7:0] c1, c2; // command slots of one frame
   reg [55:0] rx; // bits the host saw on dout
   integer num_errors = 0;
   integer check_count = 0;
   integer n;
   wire sclk, cs_n, din, dout, dout_oe, conversion_strobe, strobe_oe, polarity_select;
   wire input_config_select, full_power, sample_hold, converting;
   wire [2:0] chan_sel;
   wire [1:0] power_mode;
   wire [3:0] pos_input;
   wire [4:0] neg_input;
   acsc_host host (.clk_sys(clk_sys), .dout(dout), .sclk(sclk), .cs_n(cs_n), .din(din));
   acsc_ctrl uut (.clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
      .shutdown_n(shutdown_n), .sar_result(sar_result), .dout(dout), .dout_oe(dout_oe),
      .conversion_strobe(conversion_strobe), .strobe_oe(strobe_oe), .chan_sel(chan_sel),
      .polarity_select(polarity_select), .input_config_select(input_config_select),
      .power_mode(power_mode), .full_power(full_power), .sample_hold(sample_hold),
      .converting(converting), .pos_input(pos_input), .neg_input(neg_input));
   always #4 clk_sys = ~clk_sys;
   function [7:0] nxt(input [7:0] s);
      nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // valid channel codes in table order
   function [2:0] sel_of(input [1:0] k);
      sel_of = (k == 2'h0) ? 3'h1 : (k == 2'h1) ? 3'h5 : (k == 2'h2) ? 3'h2 : 3'h6;
   endfunction
   task check(input [63:0] seen, input [63:0] want, input [63:0] what);
      begin
         check_count = check_count + 1;
         if (seen !== want) begin
            num_errors = num_errors + 1;
            $display("wrong value %0s expected %0h seen %0h", what, want, seen);
         end
      end
   endtask
   task test_done;
      begin
         if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (90000) @(posedge clk_sys);
      num_errors = num_errors + 1;
      test_done;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (1300) @(posedge clk_sys);
      // each mode three times, codes from the lfsr; the last four rounds overlap a second conversion
      for (n = 0; n < 12; n = n + 1) begin
         lfsr_q = nxt(lfsr_q);
         c1 = {1'b1, sel_of(lfsr_q[1:0]), lfsr_q[2], lfsr_q[3], n[1:0]};
         c2 = (n > 7) ? c1 : 8'h00;
         sar_result <= {lfsr_q[3:0], nxt(lfsr_q)};
         @(posedge clk_sys);
         host.frame(c1, c2, rx);
         check(rx, {24'h0, sar_result, 4'h0, c2[7] ? sar_result : 12'h0, 4'h0}, "result");
         check({chan_sel, polarity_select, input_config_select, power_mode}, c1[6:0], "fields");
         check(full_power, c1[1:0] == 2'h3, "power");
         check({pos_input, neg_input}, {4'h1 << lfsr_q[1:0],
            c1[2] ? 5'h10 : 5'h01 << (lfsr_q[1:0] ^ 2'h1)}, "inputs");
      end
      // shutdown in mid conversion: halted, mode left as it was
      fork
         host.frame(8'h9C, 8'h00, rx);
         begin
            repeat (560) @(posedge clk_sys);
            check({dout_oe, strobe_oe, sample_hold}, 3'h7, "pins");
            shutdown_n <= 1'b0;
            repeat (10) @(posedge clk_sys);
            check(converting, 1'b0, "abort");
            shutdown_n <= 1'b1;
         end
      join
      check(power_mode, 2'h3, "mode");
      repeat (260) @(posedge clk_sys);
      host.frame(8'h9C, 8'h00, rx);
      host.frame(8'h9F, 8'h00, rx);
      check(rx, {24'h0, sar_result, 4'h0, 12'h0, 4'h0}, "wake");
      check(power_mode, 2'h3, "mode");
      test_done;
   end
endmodule // acsc_ctrl_test

// ### acsc_defs.vh
// constants for the serial command and power control block of the converter
// Contract
// [R1] idle, chip select low: first one starts
// [R2] overlapped start only after result bit six
// [R3] only shutdown aborts an accepted conversion
// [R4] at most one conversion per 16 clocks; the code accepts an overlapped start bit 15 clocks after the last one
// [R5] host clocks 16 zeros when select tied
// [R6] reset: normal mode, ready, strobe low
// [R7] host waits reset interval before converting
// [R8] zeros out before the first conversion
// [R9] command byte msb first, fixed field layout
// [R10] polarity bit: 1 unipolar, 0 bipolar
// [R11] config bit: 1 single-ended, 0 pseudo-differential
// [R12] power field: 00 deep .. 11 normal
// [R13] low power only after conversion; full during
// [R14] shutdown overrides and halts conversion immediately
// [R15] serial input stays active when powered down
// [R16] after conversion hold programmed mode until next
// [R17] start bit forces full power at once
// [R18] host waits 2us after shutdown release
// [R19] host waits reference settle, internal reference
// [R20] host does dummy conversion from deep down
// [R21] host clock at most 4.8MHz in low modes
// [R22] conversion starts falling edge after bit eight
// [R23] strobe one period, then 12 bits msb first
// [R24] straight binary unipolar, twos complement bipolar
// [R25] channel codes map to inputs and pairs
`ifndef ACSC_DEFS_VH
`define ACSC_DEFS_VH
`define ACSC_CMD_BITS 8
`define ACSC_RES_BITS 12
`define ACSC_CONV_CLKS 16
`define ACSC_BIT_START 7
`define ACSC_BIT_SEL_HI 6
`define ACSC_BIT_SEL_LO 4
`define ACSC_BIT_POL 3
`define ACSC_BIT_CFG 2
`define ACSC_BIT_PM_HI 1
`define ACSC_BIT_PM_LO 0
`define ACSC_PM_DEEP 2'h0
`define ACSC_PM_QUICK 2'h1
`define ACSC_PM_REDUCED 2'h2
`define ACSC_PM_NORMAL 2'h3
`define ACSC_PM_RESET 2'h3
`define ACSC_B6_EDGE 4'h6
`endif

// ### acsc_host.sv
// host serial master model for the converter pins
`timescale 1ns/10ps
module acsc_host (
   input wire clk_sys,
   input wire dout,
   output reg sclk,
   output reg cs_n,
   output reg din
);
   reg [1:0] pm_q; // mode last programmed, sets the clock pace
   integer i, k, half;
   // 16 zeros, two command slots 16 clocks apart, zeros; clock idles low
   task frame(input [7:0] c1, input [7:0] c2, output [55:0] rx);
      begin
         half = (pm_q == 2'h1 || pm_q == 2'h2 || c1[1:0] == 2'h1
            || c1[1:0] == 2'h2) ? 14 : 10;
         cs_n <= 1'b0;
         for (i = 55; i >= 0; i = i - 1) begin
            din <= ({16'h0000, c1, 8'h00, c2, 16'h0000} >> i) & 56'h1;
            for (k = 1; k < half; k = k + 1) @(posedge clk_sys);
            sclk <= 1'b1;
            for (k = 0; k < half; k = k + 1) @(posedge clk_sys);
            sclk <= 1'b0;
            @(posedge clk_sys);
            rx[i] = dout; // sampled well after the rise that moved it
         end
         pm_q = c2[7] ? c2[1:0] : c1[1:0];
      end
   endtask
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
      pm_q = 2'h3;
   end
endmodule // acsc_host

// ### acsc_sync.v
// two-flop synchroniser for one level
`timescale 1ns/10ps
module acsc_sync (
   input wire clk_sys,
   input wire arst_n,
   input wire d,
   output wire q
);
   reg meta_q; // first stage, read only by second
   reg sync_q; // second stage
   //////////////////////////////////////////////////////////////////////
   // plain two stage shift
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end
   assign q = sync_q;
endmodule // acsc_sync
